// >>> bnsp_pkg.sv
package bnsp_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam logic [10:0] CLOCK_REG_BASE = 11'h7f8;

    // ------------------------------------------------------------
    // Timing, ns as printed for the slower grade
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int ADDRESS_LATENCY_NS = 100;
    localparam int SELECT_LATENCY_NS = 100;
    localparam int OUTPUT_LATENCY_NS = 55;
    localparam int WE_PULSE_NS = 70;
    localparam int CE_PULSE_NS = 75;
    localparam int DATA_SETUP_TIME_NS = 40;
    localparam int DATA_HOLD_TIME_NS = 0;
    localparam int WRITE_RECOVERY_TIME_NS = 5;
    localparam int WRITE_STROBE_FLOAT_TIME_NS = 35;

    // Least times round up, never below one cycle
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int READ_WAIT_CYC = ns_to_cyc(ADDRESS_LATENCY_NS);
    localparam int SEL_WAIT_CYC = ns_to_cyc(SELECT_LATENCY_NS);
    localparam int OE_WAIT_CYC = ns_to_cyc(OUTPUT_LATENCY_NS);
    localparam int WRITE_LOW_CYC = ns_to_cyc(CE_PULSE_NS > WE_PULSE_NS ? CE_PULSE_NS
                                                                      : WE_PULSE_NS);
    localparam int SETUP_CYC = ns_to_cyc(DATA_SETUP_TIME_NS);
    localparam int HOLD_CYC = ns_to_cyc(DATA_HOLD_TIME_NS);
    localparam int RECOVERY_CYC = ns_to_cyc(WRITE_RECOVERY_TIME_NS);
    localparam int FLOAT_CYC = ns_to_cyc(WRITE_STROBE_FLOAT_TIME_NS);
    localparam int CNT_W = 4;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic [10:0] addr;
        logic [7:0] wdata;
    } bnsp_req_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [10:0] addr;
    } bnsp_pins_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_RSEL = 6'b000010,
        ST_RWAIT = 6'b000100,
        ST_WLOW = 6'b001000,
        ST_WHOLD = 6'b010000,
        ST_RECOV = 6'b100000
    } bnsp_state_t;

endpackage

// >>> bnsp_timer.sv
`timescale 1ns/100ps
module bnsp_timer
    import bnsp_pkg::*;
#(
    parameter int W = CNT_W
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic done
);

    logic [W-1:0] left;

    assign done = (left == '0);

    // Reload wins so a new phase never inherits a stale count
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            left <= '0;
        end else if (load) begin
            left <= count;
        end else if (!done) begin
            left <= left - 1'b1;
        end
    end

endmodule

// >>> bnsp_host.sv
`timescale 1ns/100ps
// Functional notes
// - Write starts at later falling edge.
// - Host holds address through write.
// - Host idles strobes recovery time between cycles.
// - Host data setup before, hold after.
// - Host keeps output enable high writing.
module bnsp_host
    import bnsp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic supply_ok,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic rsp_clock_reg,
    output logic mem_ce_n,
    output logic mem_oe_n,
    output logic mem_we_n,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [DATA_W-1:0] mem_dq_out,
    output logic mem_dq_oe,
    input wire logic [DATA_W-1:0] mem_dq_in
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] dq_meta;
    logic [DATA_W-1:0] dq_sync;
    logic ok_meta;
    logic ok_sync;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dq_meta <= '0;
            dq_sync <= '0;
            ok_meta <= 1'b0;
            ok_sync <= 1'b0;
        end else begin
            dq_meta <= mem_dq_in;
            dq_sync <= dq_meta;
            ok_meta <= supply_ok;
            ok_sync <= ok_meta;
        end
    end

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic is_read_phase(input bnsp_state_t s);
        return (s == ST_RSEL) || (s == ST_RWAIT);
    endfunction

    function automatic logic is_write_phase(input bnsp_state_t s);
        return (s == ST_WLOW) || (s == ST_WHOLD);
    endfunction

    // Top eight locations are clock registers, not plain storage
    function automatic logic is_clock_reg(input logic [ADDR_W-1:0] a);
        return (a >= CLOCK_REG_BASE);
    endfunction

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    bnsp_state_t state;
    bnsp_state_t next_state;
    bnsp_req_t cur;
    logic tmr_load;
    logic [CNT_W-1:0] tmr_count;
    logic tmr_done;

    // Select and output enable fall together, so the later latency governs
    localparam int RD_LAT = (READ_WAIT_CYC > SEL_WAIT_CYC)
        ? ((READ_WAIT_CYC > OE_WAIT_CYC) ? READ_WAIT_CYC : OE_WAIT_CYC)
        : ((SEL_WAIT_CYC > OE_WAIT_CYC) ? SEL_WAIT_CYC : OE_WAIT_CYC);
    // Two extra cycles cover the input synchroniser
    localparam logic [CNT_W-1:0] RD_WAIT = CNT_W'(RD_LAT + 2);
    localparam logic [CNT_W-1:0] WR_LOW = CNT_W'((WRITE_LOW_CYC > SETUP_CYC)
                                                 ? WRITE_LOW_CYC : SETUP_CYC);
    localparam logic [CNT_W-1:0] WR_HOLD = CNT_W'(HOLD_CYC);
    localparam logic [CNT_W-1:0] REC_WAIT = CNT_W'(RECOVERY_CYC);

    // Blocked accesses would be lost, so hold requests below threshold
    wire start_ok = req_valid && req_ready && ok_sync;
    wire in_idle = (state == ST_IDLE);

    always_comb begin
        next_state = state;
        tmr_load = 1'b0;
        tmr_count = '0;
        case (state)
            ST_IDLE: begin
                if (start_ok) begin
                    tmr_load = 1'b1;
                    tmr_count = req_write ? WR_LOW : RD_WAIT;
                    next_state = req_write ? ST_WLOW : ST_RSEL;
                end
            end
            ST_RSEL: begin
                next_state = ST_RWAIT;
            end
            ST_RWAIT: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_count = REC_WAIT;
                    next_state = ST_RECOV;
                end
            end
            ST_WLOW: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_count = WR_HOLD;
                    next_state = ST_WHOLD;
                end
            end
            ST_WHOLD: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_count = REC_WAIT;
                    next_state = ST_RECOV;
                end
            end
            ST_RECOV: begin
                if (tmr_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    bnsp_timer #(
        .W(CNT_W)
    ) u_timer (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    // ------------------------------------------------------------
    // Pin drive, all registered
    // ------------------------------------------------------------
    wire rd_phase = is_read_phase(next_state);
    wire wr_phase = is_write_phase(next_state);
    wire next_ce_n = !(rd_phase || next_state == ST_WLOW);
    wire next_oe_n = !rd_phase;
    // Both strobes fall on one edge, so that edge starts the write
    wire next_we_n = !(next_state == ST_WLOW);
    wire next_dq_oe = wr_phase;
    wire sample = (state == ST_RWAIT) && tmr_done && !cur.write;
    wire write_done = (state == ST_WHOLD) && tmr_done && cur.write;
    wire next_ready = (next_state == ST_IDLE) && !(in_idle && start_ok);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cur <= '0;
            mem_ce_n <= 1'b1;
            mem_oe_n <= 1'b1;
            mem_we_n <= 1'b1;
            mem_dq_oe <= 1'b0;
        end else begin
            state <= next_state;
            if (start_ok) begin
                cur <= '{write: req_write, addr: req_addr, wdata: req_wdata};
            end
            mem_ce_n <= next_ce_n;
            mem_oe_n <= next_oe_n;
            mem_we_n <= next_we_n;
            mem_dq_oe <= next_dq_oe;
        end
    end

    // Address and data only move between cycles
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_addr <= '0;
            mem_dq_out <= '0;
        end else if (start_ok) begin
            mem_addr <= req_addr;
            mem_dq_out <= req_wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            rsp_clock_reg <= 1'b0;
        end else begin
            req_ready <= next_ready;
            rsp_valid <= sample || write_done;
            if (sample) begin
                rsp_rdata <= dq_sync;
                rsp_clock_reg <= is_clock_reg(cur.addr);
            end
        end
    end

endmodule

// >>> bnsp_host_properties.sv
`timescale 1ns/100ps
// ----
// Host pin discipline
// ----
module bnsp_host_checker (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic supply_ok,
    input wire logic rsp_valid,
    input wire logic mem_ce_n,
    input wire logic mem_oe_n,
    input wire logic mem_we_n,
    input wire logic [10:0] mem_addr,
    input wire logic [7:0] mem_dq_out,
    input wire logic mem_dq_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_wait;
        !rsp_valid[*3] ##[1:6] rsp_valid;
    endsequence
    property p_read_wait;
        $fell(mem_oe_n) |-> s_wait;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read data early");
    property p_write_start;
        $fell(mem_we_n) |-> !mem_ce_n && mem_oe_n && mem_dq_oe;
    endproperty
    a_write_start: assert property (p_write_start) else $error("bad write start");
    property p_addr_hold;
        !mem_we_n |=> $stable(mem_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    property p_recovery;
        $rose(mem_ce_n) |-> mem_ce_n[*2];
    endproperty
    a_recovery: assert property (p_recovery) else $error("recovery too short");
    property p_data_hold;
        !mem_we_n |-> mem_dq_oe ##1 (mem_dq_oe && $stable(mem_dq_out));
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("write data unstable");
    property p_oe_write;
        !mem_we_n |-> mem_oe_n;
    endproperty
    a_oe_write: assert property (p_oe_write) else $error("output enable in write");
    // Two sync stages plus registered pins
    property p_no_access;
        !supply_ok[*5] |=> !$fell(mem_ce_n);
    endproperty
    a_no_access: assert property (p_no_access) else $error("access on low supply");
endmodule
bind bnsp_host bnsp_host_checker i_chk(.mclk(mclk), .rst_n(rst_n), .supply_ok(supply_ok),
    .rsp_valid(rsp_valid), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
    .mem_addr(mem_addr), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));

// >>> bnsp_sram_model.sv
`timescale 1ns/100ps
// ----
// Behavioural memory
// ----
module bnsp_sram_model
    import bnsp_pkg::*;
(
    input wire logic power_ok,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] host_dq,
    input wire logic host_oe,
    output logic [DATA_W-1:0] dq
);
    // Contents survive supply loss
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [DATA_W-1:0] junk = 8'h5a;
    logic valid = 1'b0;
    wire sel = !ce_n && power_ok;
    wire rd = sel && we_n && !oe_n;
    wire wr = sel && !we_n;
    // Floating bus never shows a stale value
    always #(CLK_PERIOD_NS) junk = ~junk;
    always @(addr, rd) begin
        valid <= #5 1'b0;
        valid <= #(ADDRESS_LATENCY_NS) rd;
    end
    always @(negedge wr) mem[addr] = host_oe ? host_dq : junk;
    assign dq = host_oe ? host_dq : (rd ? (valid ? mem[addr] : ~junk) : junk);
endmodule

// >>> bytewide_nv_sram_port_bench.sv
`timescale 1ns/100ps
// ----
// Bench
// ----
module bytewide_nv_sram_port_bench;
    import bnsp_pkg::*;
    typedef struct packed {
        logic [10:0] addr;
        logic [7:0] data;
        logic clk;
    } bnsp_row_t;
    bnsp_row_t rows [4] = '{'{11'h000, 8'ha5, 1'b0}, '{11'h7f7, 8'h3c, 1'b0},
        '{11'h7f8, 8'h81, 1'b1}, '{11'h7ff, 8'h99, 1'b1}};
    logic mclk = 0, rst_n = 0, req_valid = 0, req_write = 0, supply_ok = 1;
    logic [10:0] req_addr = 0;
    logic [7:0] req_wdata = 0;
    logic req_ready, rsp_valid, rsp_clock_reg, ce_n, oe_n, we_n, dq_oe;
    logic [7:0] rsp_rdata, dq_out, dq_in;
    logic [10:0] addr;
    int miscompares = 0, n_checks = 0;
    always #50 mclk = ~mclk;
    bnsp_host i_dut(.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .supply_ok(supply_ok),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_clock_reg(rsp_clock_reg), .mem_ce_n(ce_n), .mem_oe_n(oe_n), .mem_we_n(we_n),
        .mem_addr(addr), .mem_dq_out(dq_out), .mem_dq_oe(dq_oe), .mem_dq_in(dq_in));
    bnsp_sram_model i_mem(.power_ok(supply_ok), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .addr(addr), .host_dq(dq_out), .host_oe(dq_oe), .dq(dq_in));
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tick;
        @(posedge mclk);
        #10;
    endtask
    // Holds the request until the taking edge drops ready
    task access(input logic w, input logic [10:0] a, input logic [7:0] d);
        int k;
        k = 0;
        while (req_ready !== 1'b1 && k < 50) begin
            tick;
            k++;
        end
        {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
        do begin
            tick;
            k++;
        end while (req_ready !== 1'b0 && k < 100);
        req_valid = 0;
        while (rsp_valid !== 1'b1 && k < 150) begin
            tick;
            k++;
        end
        chk("handshake", {7'h0, k < 150}, 8'h01);
    endtask
    task wrap_up;
        if (miscompares == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        #10 rst_n = 1;
        foreach (rows[i]) begin
            access(1'b1, rows[i].addr, rows[i].data);
            access(1'b0, rows[i].addr, 8'h00);
            chk("rdata", rsp_rdata, rows[i].data);
            chk("clock_reg", {7'h0, rsp_clock_reg}, {7'h0, rows[i].clk});
        end
        supply_ok = 0;
        repeat (3) tick;
        {req_valid, req_write, req_addr} = {1'b1, 1'b0, 11'h000};
        repeat (10) begin
            tick;
            chk("ce_n low supply", {7'h0, ce_n}, 8'h01);
        end
        supply_ok = 1;
        access(1'b0, 11'h000, 8'h00);
        chk("rdata after supply", rsp_rdata, 8'ha5);
        {req_valid, req_write, req_addr, req_wdata} = {1'b1, 1'b1, 11'h000, 8'h11};
        repeat (2) tick;
        rst_n = 0;
        req_valid = 0;
        #1 chk("reset pins", {4'h0, ce_n, we_n, dq_oe, req_ready}, 8'h0c);
        repeat (2) tick;
        rst_n = 1;
        access(1'b0, 11'h7ff, 8'h00);
        chk("rdata after reset", rsp_rdata, 8'h99);
        wrap_up;
    end
    initial begin
        #2000000;
        miscompares++;
        wrap_up;
    end
endmodule
